// >>> shared/port_pkg.sv
package port_pkg;
	localparam int          PORT_W       = 8;
	localparam int          KEY_W        = 6;
	localparam logic [7:0]  LATCH_RST    = 8'h00;
	localparam logic [7:0]  DIR_RST      = 8'hff;
	localparam logic [7:0]  BIDIR_RST    = 8'h00;
	localparam logic [1:0]  KEY_PAD      = 2'h0;
	// access selectors from the core
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_LATCH,
		SEL_BIDIR,
		SEL_DIR,
		SEL_KEY
	} port_sel_t;
	// logic ops for read-modify-write of the latch
	typedef enum logic [1:0] {
		OP_MOVE,
		OP_AND,
		OP_OR,
		OP_XOR
	} port_op_t;
endpackage

// >>> src/parallel_ports.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_ports
	import port_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              reset,
	// core access
	input  wire port_sel_t         acc_sel,
	input  wire logic              acc_wr,
	input  wire port_op_t          acc_op,
	input  wire logic [PORT_W-1:0] acc_wdata,
	output var  logic [PORT_W-1:0] acc_rdata,
	input  wire logic [KEY_W-1:0]  key_test_mask,
	output var  logic              key_test_hit,
	// latched output port
	output var  logic [PORT_W-1:0] latched_output_port,
	// bidirectional port pins
	input  wire logic [PORT_W-1:0] bidirectional_port_in,
	output var  logic [PORT_W-1:0] bidirectional_port_out,
	output var  logic [PORT_W-1:0] bidirectional_port_oe_n,
	// key input port pins
	input  wire logic [KEY_W-1:0]  key_input_port,
	// external bus cycle requests from the core
	input  wire logic              bus_write_cycle,
	input  wire logic              bus_read_cycle,
	input  wire logic              halted,
	input  wire logic [PORT_W-1:0] bus_wdata,
	// strobes, active low, each with its own enable
	output var  logic              write_strobe_n_out,
	output var  logic              write_strobe_oe_n,
	output var  logic              read_strobe_n_out,
	output var  logic              read_strobe_oe_n,
	// external data bus pins
	input  wire logic [PORT_W-1:0] ext_data_bus_in,
	output var  logic [PORT_W-1:0] ext_data_bus_out,
	output var  logic              ext_data_bus_oe_n,
	output var  logic [PORT_W-1:0] ext_data_bus_rdata,
	// timer
	input  wire logic              timer_count_tick,
	output var  logic              timer_square_out
);

	// port state and next values
	logic [PORT_W-1:0] latch_r;
	logic [PORT_W-1:0] latch_nxt;
	logic [PORT_W-1:0] bidir_r;
	logic [PORT_W-1:0] bidir_nxt;
	logic [PORT_W-1:0] dir_r;
	logic [PORT_W-1:0] dir_nxt;
	// pin synchronisers
	logic [PORT_W-1:0] bidir_meta_r;
	logic [PORT_W-1:0] bidir_sync_r;
	logic [KEY_W-1:0]  key_meta_r;
	logic [KEY_W-1:0]  key_sync_r;
	logic [PORT_W-1:0] db_meta_r;
	logic [PORT_W-1:0] db_sync_r;
	// answer and pin next values
	logic [PORT_W-1:0] rdata_nxt;
	logic              key_hit_nxt;
	logic              timer_r;
	logic [PORT_W-1:0] latch_op_val;
	logic [PORT_W-1:0] bidir_view;
	logic [PORT_W-1:0] bidir_op_val;
	logic              wr_stb_nxt;
	logic              rd_stb_nxt;
	logic              db_oe_n_nxt;
	logic              timer_nxt;

	// access decode from the core selector
	// only one target can be written in a cycle
	wire               wr_latch = acc_wr && (acc_sel == SEL_LATCH);
	wire               wr_bidir = acc_wr && (acc_sel == SEL_BIDIR);
	wire               wr_dir   = acc_wr && (acc_sel == SEL_DIR);
	wire               db_drive = bus_write_cycle && !halted;

	// bidirectional pins: two flops, nothing reads the first
	// a bit caught mid-change settles before any read sees it
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			bidir_meta_r <= '0;
			bidir_sync_r <= '0;
		end
		else
		begin
			bidir_meta_r <= bidirectional_port_in;
			bidir_sync_r <= bidir_meta_r;
		end
	end

	// key pins: same two-flop chain
	// adds two cycles of delay to key reads and key tests
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			key_meta_r <= '0;
			key_sync_r <= '0;
		end
		else
		begin
			key_meta_r <= key_input_port;
			key_sync_r <= key_meta_r;
		end
	end

	// data bus pins: same two-flop chain
	// limitation: bus read data trails the pins by three edges
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			db_meta_r <= '0;
			db_sync_r <= '0;
		end
		else
		begin
			db_meta_r <= ext_data_bus_in;
			db_sync_r <= db_meta_r;
		end
	end

	// shared function for in-place latch operations
	// one function serves latch, bidirectional port and direction,
	// but each of its three calls builds its own copy of the ops
	function automatic logic [PORT_W-1:0] apply_op(
		input port_op_t          op,
		input logic [PORT_W-1:0] cur,
		input logic [PORT_W-1:0] arg
	);
		unique case (op)
			OP_MOVE: apply_op = arg;
			OP_AND:  apply_op = cur & arg;
			OP_OR:   apply_op = cur | arg;
			OP_XOR:  apply_op = cur ^ arg;
		endcase
	endfunction

	assign bidir_view = (bidir_r & ~dir_r) | (bidir_sync_r & dir_r);

	// read-modify-write of the latch
	// the bidirectional op works on what a read would return,
	// so input-line bits never leak a hidden latch value
	assign latch_op_val = apply_op(acc_op, latch_r, acc_wdata);
	assign bidir_op_val = apply_op(acc_op, bidir_view, acc_wdata);

	// latch changes only on its own write
	assign latch_nxt = wr_latch ? latch_op_val : latch_r;

	assign bidir_nxt = wr_bidir ?
		((bidir_op_val & ~dir_r) | (bidir_r & dir_r)) : bidir_r;

	// writable any time, pins follow next cycle
	assign dir_nxt = wr_dir ? apply_op(acc_op, dir_r, acc_wdata) : dir_r;

	// read data selection
	// codes past the key selector are illegal and read as zero
	// so a stray selector never echoes stale port data
	always_comb
	begin
		rdata_nxt = '0;
		unique case (acc_sel)
			SEL_NONE:  rdata_nxt = '0;
			SEL_LATCH: rdata_nxt = latch_r;
			SEL_BIDIR: rdata_nxt = bidir_view;
			SEL_DIR:   rdata_nxt = dir_r;
			// key pins into low six bits
			SEL_KEY:   rdata_nxt = {KEY_PAD, key_sync_r};
			default:   rdata_nxt = '0;
		endcase
	end

	// key test straight from pins, no move needed
	assign key_hit_nxt = |(key_sync_r & key_test_mask);

	// write strobe low only inside a write cycle
	// level and enable share one value, so they never disagree
	assign wr_stb_nxt = ~bus_write_cycle;

	// read strobe low only inside a read cycle
	assign rd_stb_nxt = ~bus_read_cycle;

	// bus enable only for an output cycle, never halted
	// a write requested while halted still strobes but loses its bus drive, not held off
	assign db_oe_n_nxt = ~db_drive;

	// one toggle per timer count gives the square wave
	// the count itself lives in the timer block outside
	assign timer_nxt = timer_count_tick ? ~timer_r : timer_r;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			latch_r <= LATCH_RST;
			bidir_r <= BIDIR_RST;
			dir_r   <= DIR_RST;
		end
		else
		begin
			latch_r <= latch_nxt;
			bidir_r <= bidir_nxt;
			dir_r   <= dir_nxt;
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			timer_r <= 1'b0;
		else
			timer_r <= timer_nxt;
	end

	// port pins follow the next values, so a write shows on
	// the pins at the same edge the latch takes it
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			latched_output_port     <= LATCH_RST;
			bidirectional_port_out  <= BIDIR_RST;
			bidirectional_port_oe_n <= '1;
		end
		else
		begin
			latched_output_port     <= latch_nxt;
			bidirectional_port_out  <= bidir_nxt;
			// new output line drives held latch
			bidirectional_port_oe_n <= dir_nxt;
		end
	end

	// strobes: level and enable move together, so a released
	// pin never shows a stale low to the far side
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			write_strobe_n_out <= 1'b1;
			write_strobe_oe_n  <= 1'b1;
			read_strobe_n_out  <= 1'b1;
			read_strobe_oe_n   <= 1'b1;
		end
		else
		begin
			// write strobe only in write cycles
			write_strobe_n_out <= wr_stb_nxt;
			write_strobe_oe_n  <= wr_stb_nxt;
			// read strobe only in read cycles
			read_strobe_n_out  <= rd_stb_nxt;
			read_strobe_oe_n   <= rd_stb_nxt;
		end
	end

	// data bus drive and captured bus levels
	// the bus data register always follows, only the enable gates
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			ext_data_bus_out   <= '0;
			ext_data_bus_oe_n  <= 1'b1;
			ext_data_bus_rdata <= '0;
		end
		else
		begin
			ext_data_bus_out   <= bus_wdata;
			// driven only when outputting, not halted
			ext_data_bus_oe_n  <= db_oe_n_nxt;
			ext_data_bus_rdata <= db_sync_r;
		end
	end

	// answers to the core, one edge after the selector
	// registered so the read path never forms a loop with the core
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			acc_rdata    <= '0;
			key_test_hit <= 1'b0;
		end
		else
		begin
			acc_rdata    <= rdata_nxt;
			key_test_hit <= key_hit_nxt;
		end
	end

	// timer pin copies the next timer value, keeping it
	// in step with the internal toggle flop
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			timer_square_out <= 1'b0;
		else
			timer_square_out <= timer_nxt;
	end

endmodule // parallel_ports
`default_nettype wire

// >>> tb/mcu_parallel_ports_and_strobes_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_parallel_ports_and_strobes_bench
	import port_pkg::*;
;
	logic clock = '0, reset = '1, acc_wr = '0, rd_vld = '0, vld_q = '0;
	logic bus_write_cycle = '0, bus_read_cycle = '0, halted = '0;
	logic timer_count_tick = '0, key_test_hit, timer_square_out;
	logic write_strobe_n_out, write_strobe_oe_n, read_strobe_n_out;
	logic read_strobe_oe_n, ext_data_bus_oe_n;
	port_sel_t acc_sel = SEL_NONE;
	port_op_t acc_op = OP_MOVE, o;
	logic [7:0] acc_wdata = '0, bus_wdata = '0, pin_drive = '0, mem_data = '0;
	logic [7:0] acc_rdata, latched_output_port, bidirectional_port_in;
	logic [7:0] bidirectional_port_out, bidirectional_port_oe_n, ext_data_bus_in;
	logic [7:0] ext_data_bus_out, ext_data_bus_rdata, dir, bl, lv, e, expq[$];
	logic [7:0] w, bq[$];
	logic bv = '0, bv_q = '0, tv = '0;
	wire [7:0] stb_view = {4'h0, write_strobe_n_out, write_strobe_oe_n,
		read_strobe_n_out, read_strobe_oe_n};
	logic [5:0] key_test_mask = '0, key_press = '0, key_input_port;
	logic [31:0] seed = 26393;
	int failures = 0, total_checks = 0, cyc = 0;
	parallel_ports u_dut(.*);
	port_partner u_far(.pin_drive, .oe_n(bidirectional_port_oe_n),
		.out(bidirectional_port_out), .key_press, .bus_oe_n(ext_data_bus_oe_n),
		.bus_out(ext_data_bus_out), .mem_data, .pins(bidirectional_port_in),
		.bus_in(ext_data_bus_in), .keys(key_input_port));
	initial forever #5 clock = ~clock;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input port_sel_t s, input port_op_t p, input logic [7:0] d);
		@(posedge clock);
		acc_sel <= s;
		acc_op <= p;
		acc_wdata <= d;
		acc_wr <= 1'b1;
		@(posedge clock);
		acc_wr <= 1'b0;
	endtask
	// read request notes its expectation for the watcher
	task automatic rd(input port_sel_t s, input logic [7:0] x);
		@(posedge clock);
		acc_sel <= s;
		rd_vld <= 1'b1;
		expq.push_back(x);
		@(posedge clock);
		rd_vld <= 1'b0;
	endtask
	// read data lands at the same edge that samples the request
	always @(posedge clock) vld_q <= rd_vld;
	always @(negedge clock) if (vld_q) chk(acc_rdata, expq.pop_front());
	// bus cycle results land one edge after the request
	always @(posedge clock) bv_q <= bv;
	always @(negedge clock)
		if (bv_q)
		begin
			chk(stb_view, bq.pop_front());
			chk({7'h0, ext_data_bus_oe_n}, bq.pop_front());
			chk(ext_data_bus_out, bq.pop_front());
		end
	// hang guard, well above the expected run length
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			end_sim();
		end
	end
	initial
	begin
		repeat (8) @(posedge clock);
		chk(latched_output_port, LATCH_RST);
		chk(bidirectional_port_oe_n, 8'hff);
		chk({ext_data_bus_oe_n, write_strobe_oe_n, timer_square_out, 5'h0}, 8'hc0);
		reset <= 1'b0;
		rd(SEL_DIR, DIR_RST);
		rd(SEL_NONE, 8'h00);
		lv = LATCH_RST;
		for (int i = 0; i < 8; i++)
		begin
			e = rnd();
			o = port_op_t'(i[1:0]);
			lv = o == OP_AND ? lv & e : o == OP_OR ? lv | e : o == OP_XOR ? lv ^ e : e;
			wr(SEL_LATCH, o, e);
			rd(SEL_LATCH, lv);
			chk(latched_output_port, lv);
		end
		bl = BIDIR_RST;
		// random directions; input lines show pins, not latch
		for (int i = 0; i < 6; i++)
		begin
			dir = rnd();
			e = rnd();
			wr(SEL_DIR, OP_MOVE, dir);
			wr(SEL_BIDIR, OP_MOVE, e);
			bl = (bl & dir) | (e & ~dir);
			pin_drive <= rnd();
			repeat (4) @(posedge clock);
			rd(SEL_BIDIR, (bl & ~dir) | (pin_drive & dir));
			chk(bidirectional_port_out & ~dir, bl & ~dir);
			wr(SEL_DIR, OP_MOVE, 8'h00);
			rd(SEL_BIDIR, bl);
		end
		for (int i = 0; i < 4; i++)
		begin
			e = rnd();
			key_press <= e[5:0];
			key_test_mask <= e[7:2];
			repeat (4) @(posedge clock);
			rd(SEL_KEY, {2'h0, ~key_press});
			chk({7'h0, key_test_hit}, {7'h0, |(~key_press & key_test_mask)});
		end
		// random bus cycles, halts and ticks for the checker
		repeat (300)
		begin
			@(posedge clock);
			e = rnd();
			w = rnd();
			bus_write_cycle <= e[0];
			bus_read_cycle <= e[1] & ~e[0];
			halted <= e[2] & e[3];
			timer_count_tick <= e[4];
			bus_wdata <= w;
			mem_data <= e;
			bv <= 1'b1;
			tv ^= e[4];
			bq.push_back({4'h0, {2{~e[0]}}, {2{~(e[1] & ~e[0])}}});
			bq.push_back({7'h0, ~(e[0] & ~(e[2] & e[3]))});
			bq.push_back(w);
		end
		@(posedge clock);
		bv <= 1'b0;
		bus_write_cycle <= 1'b0;
		bus_read_cycle <= 1'b0;
		timer_count_tick <= 1'b0;
		repeat (6) @(posedge clock);
		chk(ext_data_bus_rdata, mem_data);
		chk({7'h0, timer_square_out}, {7'h0, tv});
		end_sim();
	end
endmodule // mcu_parallel_ports_and_strobes_bench
bind parallel_ports parallel_ports_monitor u_mon(.*);
`default_nettype wire

// >>> tb/parallel_ports_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_ports_monitor
	import port_pkg::*;
(
	// watched top ports
	input wire logic       clock,
	input wire logic       reset,
	input wire port_sel_t  acc_sel,
	input wire logic       acc_wr,
	input wire port_op_t   acc_op,
	input wire logic [7:0] acc_wdata,
	input wire logic [7:0] latched_output_port,
	input wire logic [7:0] bidirectional_port_out,
	input wire logic [7:0] bidirectional_port_oe_n,
	input wire logic       bus_write_cycle,
	input wire logic       bus_read_cycle,
	input wire logic       halted,
	input wire logic       write_strobe_oe_n,
	input wire logic       read_strobe_oe_n,
	input wire logic       ext_data_bus_oe_n,
	input wire logic       timer_count_tick,
	input wire logic       timer_square_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// decoded write requests
	wire lw = acc_wr && acc_sel == SEL_LATCH;
	wire mv = acc_op == OP_MOVE;
	wire dw = acc_wr && acc_sel == SEL_DIR && mv;
	wire bw = acc_wr && acc_sel == SEL_BIDIR;
	property p_latch_hold; !lw |=> $stable(latched_output_port); endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch moved");
	property p_latch_move;
		lw && mv |=> latched_output_port == $past(acc_wdata); endproperty
	a_latch_move: assert property (p_latch_move) else $error("latch move");
	property p_dir_take;
		dw |=> bidirectional_port_oe_n == $past(acc_wdata); endproperty
	a_dir_take: assert property (p_dir_take) else $error("dir late");
	// input-line latch bits must not change on a port write
	property p_bidir_ign; bw |=> ((bidirectional_port_out ^
		$past(bidirectional_port_out)) & $past(bidirectional_port_oe_n)) == 8'h00;
	endproperty
	a_bidir_ign: assert property (p_bidir_ign) else $error("input bit written");
	property p_wr_stb; 1 |=> write_strobe_oe_n == !$past(bus_write_cycle);
	endproperty
	a_wr_stb: assert property (p_wr_stb) else $error("write strobe");
	property p_rd_stb; bus_read_cycle |-> ##1 !read_strobe_oe_n; endproperty
	a_rd_stb: assert property (p_rd_stb) else $error("read strobe");
	property p_bus_drv; 1 |=>
		ext_data_bus_oe_n == !($past(bus_write_cycle) && !$past(halted));
	endproperty
	a_bus_drv: assert property (p_bus_drv) else $error("data bus drive");
	property p_timer; 1 |=> (timer_square_out ^ $past(timer_square_out)) ==
		$past(timer_count_tick); endproperty
	a_timer: assert property (p_timer) else $error("timer toggle");
endmodule // parallel_ports_monitor
`default_nettype wire

// >>> tb/port_partner.sv
`timescale 1ns/1ps
`default_nettype none
module port_partner
(
	// device pins and far-side values
	input  wire logic [7:0] pin_drive,
	input  wire logic [7:0] oe_n,
	input  wire logic [7:0] out,
	input  wire logic [5:0] key_press,
	input  wire logic       bus_oe_n,
	input  wire logic [7:0] bus_out,
	input  wire logic [7:0] mem_data,
	output logic      [7:0] pins,
	output logic      [7:0] bus_in,
	output logic      [5:0] keys
);
	assign pins = (out & ~oe_n) | (pin_drive & oe_n);
	assign keys = ~key_press;
	assign bus_in = bus_oe_n ? mem_data : bus_out;
endmodule // port_partner
`default_nettype wire
